// [src/sfr_defines.svh]
// Register locations, field masks and reset values of the second SFR bank.
// Assumes locations are word indices: byte address is four times the index.
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define SFR_ADDR_W        11
`define SFR_LOC_W         9
`define SFR_RESP_OKAY     2'h0

// ----------------------------------------------------------------------
// Register locations (indices)
// ----------------------------------------------------------------------
`define SFR_LOC_INDIRECT  9'h080
`define SFR_LOC_OPTIONS   9'h081
`define SFR_LOC_PC_LOW    9'h082
`define SFR_LOC_STATUS    9'h083
`define SFR_LOC_POINTER   9'h084
`define SFR_LOC_DIR_A     9'h085
`define SFR_LOC_DIR_B     9'h086
`define SFR_LOC_DIR_C     9'h087
`define SFR_LOC_DIR_D     9'h088
`define SFR_LOC_DIR_E     9'h089
`define SFR_LOC_PC_BUF    9'h08a
`define SFR_LOC_INT_CTL   9'h08b
`define SFR_LOC_PERIPHERAL_INTERRUPT_ENABLES_1      9'h08c
`define SFR_LOC_PERIPHERAL_INTERRUPT_ENABLES_2      9'h08d
`define SFR_LOC_RST_CAUSE 9'h08e
`define SFR_LOC_SSP_CTL2  9'h091
`define SFR_LOC_T2_PERIOD 9'h092
`define SFR_LOC_SSP_ADDR  9'h093
`define SFR_LOC_SSP_STAT  9'h094
`define SFR_LOC_TX_CTL    9'h098
`define SFR_LOC_BAUD_DIV  9'h099
`define SFR_LOC_CMP_CTL   9'h09c
`define SFR_LOC_VREF_CTL  9'h09d
`define SFR_LOC_ADC_LOW   9'h09e
`define SFR_LOC_ADC_CFG1  9'h09f
`define SFR_LOC_NV_ADDR_H 9'h10f

// ----------------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------------
`define SFR_WM_FULL       8'hff
`define SFR_WM_STATUS     8'he7
`define SFR_WM_DIR_A      8'h3f
`define SFR_WM_DIR_E      8'h37
`define SFR_WM_PC_BUF     8'h1f
`define SFR_WM_PERIPHERAL_INTERRUPT_ENABLES_2       8'h59
`define SFR_WM_RST_CAUSE  8'h03
`define SFR_WM_SSP_CTL2   8'hbf
`define SFR_WM_SSP_STAT   8'hc0
`define SFR_WM_TX_CTL     8'hf5
`define SFR_WM_CMP_CTL    8'h3f
`define SFR_WM_VREF_CTL   8'hef
`define SFR_WM_ADC_CFG1   8'hcf
`define SFR_WM_NV_ADDR_H  8'h1f
`define SFR_NV_BIT4       8'h10
`define SFR_WM_NONE       8'h00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFR_RST_ZERO      8'h00
`define SFR_RST_ONES      8'hff
`define SFR_RST_DIR_A     8'h3f
`define SFR_RST_LOW3      8'h07

// ----------------------------------------------------------------------
// Shared (all-bank) locations, low seven bits
// ----------------------------------------------------------------------
`define SFR_BANK_MASK     9'h07f

`endif

// [src/sfr_pkg.sv]
// Types shared by the SFR bank register file.
// Assumes sfr_defines.svh is on the include path.
`include "sfr_defines.svh"

package sfr_pkg;
  typedef logic [`SFR_LOC_W-1:0]  sfr_loc_t;
  typedef logic [`SFR_ADDR_W-1:0] sfr_addr_t;
  typedef logic [7:0]             sfr_byte_t;
endpackage

// [src/sfr_cell.sv]
// One 8-bit register cell with writable mask and hardware clear.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns

module sfr_cell
#(
  parameter logic [7:0] RST   = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] hw_clr,
  output logic      [7:0] q
);

  // Only bits in the mask hold state; others stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= RST & WMASK;
    else if (we)
      q <= wdata & WMASK & ~hw_clr;   // Hardware event beats the write
    else
      q <= q & ~hw_clr;
  end

endmodule // sfr_cell

// [src/sfr_bank1.sv]
// Bank-one special register file behind an AXI4-Lite slave.
// Assumes core-side strobes are on aclk; status inputs are same-clock.
//
// Summary of operation
// - Unimplemented addresses and bit positions read back as zero.
// - No address exists for reading or writing the upper program counter byte.
// - Five-bit buffer holds counter bits 12..8 and loads the upper byte.
// - Shared core registers hit the same storage from every bank.
// - Small variants lack port D/E direction registers; they read zero.
// - Bit 4 of nonvolatile address high exists only on large-memory variants.
`timescale 1ns/1ns
`include "sfr_defines.svh"

module sfr_bank1
#(
  parameter bit HAS_PORT_DE = 1'b1,
  parameter bit LARGE_MEM   = 1'b1,
  parameter int ADDR_W      = `SFR_ADDR_W
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [1:0]        status_timeout_powerdown,
  input  wire logic [1:0]        slave_port_buffer_flags,
  input  wire logic [5:0]        serial_status_bits,
  input  wire logic              serial_ack_status,
  input  wire logic              tx_shift_empty,
  input  wire logic [1:0]        comparator_outputs,
  input  wire logic              por_event,
  input  wire logic              bor_event,
  input  wire logic              pc_high_load,
  output logic [4:0]             pc_high,
  output logic [25*8-1:0]        sfr_image
);
  import sfr_pkg::*;

  // ----------------------------------------------------------------------
  // Register table
  // ----------------------------------------------------------------------
  localparam int NSLOT = 25;

  localparam sfr_loc_t SLOT_LOC [NSLOT] = '{
    `SFR_LOC_OPTIONS,   `SFR_LOC_PC_LOW,    `SFR_LOC_STATUS,
    `SFR_LOC_POINTER,   `SFR_LOC_DIR_A,     `SFR_LOC_DIR_B,
    `SFR_LOC_DIR_C,     `SFR_LOC_DIR_D,     `SFR_LOC_DIR_E,
    `SFR_LOC_PC_BUF,    `SFR_LOC_INT_CTL,   `SFR_LOC_PERIPHERAL_INTERRUPT_ENABLES_1,
    `SFR_LOC_PERIPHERAL_INTERRUPT_ENABLES_2,      `SFR_LOC_RST_CAUSE, `SFR_LOC_SSP_CTL2,
    `SFR_LOC_T2_PERIOD, `SFR_LOC_SSP_ADDR,  `SFR_LOC_SSP_STAT,
    `SFR_LOC_TX_CTL,    `SFR_LOC_BAUD_DIV,  `SFR_LOC_CMP_CTL,
    `SFR_LOC_VREF_CTL,  `SFR_LOC_ADC_LOW,   `SFR_LOC_ADC_CFG1,
    `SFR_LOC_NV_ADDR_H
  };

  localparam sfr_byte_t SLOT_WM [NSLOT] = '{
    `SFR_WM_FULL,       `SFR_WM_FULL,       `SFR_WM_STATUS,
    `SFR_WM_FULL,       `SFR_WM_DIR_A,      `SFR_WM_FULL,
    `SFR_WM_FULL,       `SFR_WM_FULL,       `SFR_WM_DIR_E,
    `SFR_WM_PC_BUF,     `SFR_WM_FULL,       `SFR_WM_FULL,
    `SFR_WM_PERIPHERAL_INTERRUPT_ENABLES_2,       `SFR_WM_RST_CAUSE,  `SFR_WM_SSP_CTL2,
    `SFR_WM_FULL,       `SFR_WM_FULL,       `SFR_WM_SSP_STAT,
    `SFR_WM_TX_CTL,     `SFR_WM_FULL,       `SFR_WM_CMP_CTL,
    `SFR_WM_VREF_CTL,   `SFR_WM_FULL,       `SFR_WM_ADC_CFG1,
    `SFR_WM_NV_ADDR_H
  };

  localparam sfr_byte_t SLOT_RST [NSLOT] = '{
    `SFR_RST_ONES,      `SFR_RST_ZERO,      `SFR_RST_ZERO,
    `SFR_RST_ZERO,      `SFR_RST_DIR_A,     `SFR_RST_ONES,
    `SFR_RST_ONES,      `SFR_RST_ONES,      `SFR_RST_LOW3,
    `SFR_RST_ZERO,      `SFR_RST_ZERO,      `SFR_RST_ZERO,
    `SFR_RST_ZERO,      `SFR_RST_ZERO,      `SFR_RST_ZERO,
    `SFR_RST_ONES,      `SFR_RST_ZERO,      `SFR_RST_ZERO,
    `SFR_RST_ZERO,      `SFR_RST_ZERO,      `SFR_RST_LOW3,
    `SFR_RST_ZERO,      `SFR_RST_ZERO,      `SFR_RST_ZERO,
    `SFR_RST_ZERO
  };

  // Slots that are mirrored into every bank
  localparam bit SLOT_SHARED [NSLOT] = '{
    1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0
  };

  localparam int SLOT_STATUS = 2;
  localparam int SLOT_DIR_D  = 7;
  localparam int SLOT_DIR_E  = 8;
  localparam int SLOT_PC_BUF = 9;
  localparam int SLOT_RSTCS  = 13;
  localparam int SLOT_CTL2   = 14;
  localparam int SLOT_SSTAT  = 17;
  localparam int SLOT_TXCTL  = 18;
  localparam int SLOT_CMP    = 20;
  localparam int SLOT_NVADR  = 24;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < `SFR_ADDR_W)
  begin : g_addr_check
    $error("sfr_bank1: ADDR_W too small for the register map");
  end

  // ----------------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------------
  logic      aw_held;
  logic      w_held;
  sfr_loc_t  aw_loc;
  sfr_byte_t w_byte;
  logic      w_lane0;
  logic      wr_fire;
  sfr_byte_t q      [NSLOT];
  sfr_byte_t impl   [NSLOT];
  sfr_byte_t ro_val [NSLOT];
  sfr_byte_t ro_msk [NSLOT];
  logic      we     [NSLOT];
  sfr_byte_t clr    [NSLOT];
  sfr_byte_t next_rdata;

  // Location match: exact, or low seven bits for mirrored slots
  function automatic logic hits(input sfr_loc_t loc, input int i);
    logic same;
    same = (loc == SLOT_LOC[i]);
    if (SLOT_SHARED[i])
      same = ((loc & `SFR_BANK_MASK) == (SLOT_LOC[i] & `SFR_BANK_MASK));
    return same;
  endfunction

  // ----------------------------------------------------------------------
  // Hardware-owned read-only bits
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NSLOT; i++)
    begin
      ro_val[i] = 8'h00;
      ro_msk[i] = 8'h00;
      clr[i]    = 8'h00;
    end
    ro_msk[SLOT_STATUS] = 8'h18;
    ro_val[SLOT_STATUS] = {3'h0, status_timeout_powerdown, 3'h0};
    ro_msk[SLOT_DIR_E]  = HAS_PORT_DE ? 8'hc0 : 8'h00;
    ro_val[SLOT_DIR_E]  = {slave_port_buffer_flags, 6'h00};
    ro_msk[SLOT_CTL2]   = 8'h40;
    ro_val[SLOT_CTL2]   = {1'b0, serial_ack_status, 6'h00};
    ro_msk[SLOT_SSTAT]  = 8'h3f;
    ro_val[SLOT_SSTAT]  = {2'h0, serial_status_bits};
    ro_msk[SLOT_TXCTL]  = 8'h02;
    ro_val[SLOT_TXCTL]  = {6'h00, tx_shift_empty, 1'b0};
    ro_msk[SLOT_CMP]    = 8'hc0;
    ro_val[SLOT_CMP]    = {comparator_outputs, 6'h00};
    // Power-on and brown-out events clear their cause bits
    clr[SLOT_RSTCS]     = {6'h00, por_event, bor_event};
  end

  // ----------------------------------------------------------------------
  // Register cells
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NSLOT; i++)
  begin : g_slot
    // port D/E direction absent on small variants
    // nonvolatile address bit 4 only on large memory
    localparam sfr_byte_t WM =
      ((i == SLOT_DIR_D || i == SLOT_DIR_E) && !HAS_PORT_DE) ? `SFR_WM_NONE :
      ((i == SLOT_NVADR) && !LARGE_MEM) ? (SLOT_WM[i] & ~`SFR_NV_BIT4) :
      SLOT_WM[i];

    // only matched, implemented bits are written
    assign we[i]   = wr_fire && w_lane0 && hits(aw_loc, i) && (WM != 8'h00);
    assign impl[i] = WM;

    sfr_cell
    #(
      .RST   (SLOT_RST[i]),
      .WMASK (WM)
    )
    u_cell
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (we[i]),
      .wdata   (w_byte),
      .hw_clr  (clr[i]),
      .q       (q[i])
    );

    assign sfr_image[i*8 +: 8] = q[i];
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  // no hit and unimplemented bits give zero
  // the upper counter byte has no location here
  always_comb
  begin
    next_rdata = 8'h00;
    for (int i = 0; i < NSLOT; i++)
    begin
      if (hits(sfr_loc_t'(s_axi_araddr[`SFR_LOC_W+1:2]), i))
        next_rdata = next_rdata | (q[i] & impl[i]) | (ro_val[i] & ro_msk[i]);
    end
  end

  // ----------------------------------------------------------------------
  // Write address and data channels
  // ----------------------------------------------------------------------
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Address channel: accept once, hold until response taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      aw_held       <= 1'b0;
      aw_loc        <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_held       <= 1'b1;
        aw_loc        <= sfr_loc_t'(s_axi_awaddr[`SFR_LOC_W+1:2]);
      end
      if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_awready <= 1'b1;
    end
  end

  // Data channel: only byte lane 0 carries register data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b1;
      w_held       <= 1'b0;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
    end
    else
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_held       <= 1'b1;
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
      end
      if (wr_fire)
        w_held <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_wready <= 1'b1;
    end
  end

  // Write response, always OKAY
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SFR_RESP_OKAY;
    end
    else
    begin
      s_axi_bresp <= `SFR_RESP_OKAY;
      if (wr_fire)
        s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  // Data captured at the address handshake, one cycle latency
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SFR_RESP_OKAY;
    end
    else
    begin
      s_axi_rresp <= `SFR_RESP_OKAY;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, next_rdata};  // Upper bits read zero
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Program counter upper byte
  // ----------------------------------------------------------------------
  // buffer transfers to the counter upper byte on load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pc_high <= 5'h00;
    else if (pc_high_load)
      pc_high <= q[SLOT_PC_BUF][4:0];
  end

endmodule // sfr_bank1

// [tb/sfr_bank1_asserts.sv]
// Checker for the bank-one register file: bus timing and map rules.
// Assumes it is bound to every sfr_bank1 instance, one clock domain.
`timescale 1ns/1ns

module sfr_bank1_chk
#(
  parameter bit HAS_PORT_DE = 1'b1,
  parameter bit LARGE_MEM   = 1'b1,
  parameter int ADDR_W      = 11
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              pc_high_load,
  input wire logic [4:0]        pc_high,
  input wire logic [25*8-1:0]   sfr_image
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [8:0] aw_loc;
  logic [8:0] ar_loc;
  logic       unm_w;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Gap in the map or the indirect slot
  function automatic logic gap(input logic [8:0] l);
    return (l[6:0] inside {7'h00, 7'h0f, 7'h10, 7'h15, 7'h16, 7'h17, 7'h1a, 7'h1b})
      && (l != 9'h10f);
  endfunction

  // Location of the write under way
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_loc <= 9'h000;
    else if (s_axi_awvalid && s_axi_awready)
      aw_loc <= s_axi_awaddr[ADDR_W-1:2];
  end
  assign ar_loc = s_axi_araddr[ADDR_W-1:2];
  assign unm_w  = gap(aw_loc);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_zero;
    s_axi_rvalid && (s_axi_rdata == 32'h0);
  endsequence

  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_rd_gap; s_rd_take ##0 gap(ar_loc) |=> s_rd_zero; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("gap read not zero");
  property p_shared;
    s_rd_take ##0 (ar_loc[6:0] == 7'h0a) |=>
      s_axi_rdata[7:0] == {3'h0, $past(sfr_image[76:72])};
  endproperty
  a_shared: assert property (p_shared) else $error("shared slot mismatch");
  property p_pc_load; pc_high_load |=> pc_high == $past(sfr_image[76:72]); endproperty
  a_pc_load: assert property (p_pc_load) else $error("upper counter not loaded");
  property p_pc_hold; $changed(pc_high) |-> $past(pc_high_load); endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("upper counter changed alone");
  property p_no_de;
    s_rd_take ##0 (!HAS_PORT_DE && (ar_loc == 9'h088 || ar_loc == 9'h089)) |=> s_rd_zero;
  endproperty
  a_no_de: assert property (p_no_de) else $error("absent direction reg nonzero");
  property p_nv_bit; !LARGE_MEM |-> !sfr_image[196]; endproperty
  a_nv_bit: assert property (p_nv_bit) else $error("absent address bit set");
  property p_wr_gap; $rose(s_axi_bvalid) && unm_w |-> $stable(sfr_image); endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("gap write changed storage");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && (s_axi_bresp == 2'h0);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_lat; s_rd_take |=> s_axi_rvalid [*1]; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
endmodule // sfr_bank1_chk

bind sfr_bank1 sfr_bank1_chk #(.HAS_PORT_DE(HAS_PORT_DE), .LARGE_MEM(LARGE_MEM), .ADDR_W(ADDR_W))
  chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .pc_high_load(pc_high_load), .pc_high(pc_high),
  .sfr_image(sfr_image));

// [tb/sfr_bank1_test.sv]
// Testbench for the bank-one register file over AXI4-Lite.
// Assumes a full variant in dut_u and a small variant in dut_s on shared inputs.
`timescale 1ns/1ns

module sfr_bank1_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [10:0] s_axi_awaddr = 11'h0, s_axi_araddr = 11'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdata_s;
  logic [1:0]  tpd = 2'h3, spf = 2'h3, cmp = 2'h3;
  logic [5:0]  ssb = 6'h2a;
  logic        ack = 1'b1, tse = 1'b1, por = 1'b0, bor = 1'b0, program_counter_low = 1'b0;
  logic [4:0]  pc_high;
  logic [2:0]  prot = 3'h0;
  int          err_total = 0;
  int          n_tests = 0;

  // Clock at 100 MHz
  always #5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Devices under test
  // ----------------------------------------------------------------
  sfr_bank1 dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .status_timeout_powerdown(tpd), .slave_port_buffer_flags(spf), .serial_status_bits(ssb),
    .serial_ack_status(ack), .tx_shift_empty(tse), .comparator_outputs(cmp),
    .por_event(por), .bor_event(bor), .pc_high_load(program_counter_low), .pc_high(pc_high), .sfr_image());
  sfr_bank1 #(.HAS_PORT_DE(1'b0), .LARGE_MEM(1'b0)) dut_s (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(prot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(rdata_s), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(s_axi_rready), .status_timeout_powerdown(tpd),
    .slave_port_buffer_flags(spf), .serial_status_bits(ssb), .serial_ack_status(ack),
    .tx_shift_empty(tse), .comparator_outputs(cmp), .por_event(por), .bor_event(bor),
    .pc_high_load(program_counter_low), .pc_high(), .sfr_image());

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] loc, input logic [7:0] d, input logic s = 1'b1,
                    input bit late = 1'b0);
    logic done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {loc, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= {3'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      // A late master raises bready only once the answer is shown
      if (s_axi_bvalid && !s_axi_bready)
        s_axi_bready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        chk8({6'h0, s_axi_bresp}, 8'h00);
      end
    end
    if (!done)
    begin
      err_total++;
      final_report();
    end
  endtask

  task automatic rd(input logic [8:0] loc, output logic [7:0] q, output logic [7:0] qs);
    logic done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {loc, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        q = s_axi_rdata[7:0];
        chk8({6'h0, s_axi_rresp}, 8'h00);
        qs = rdata_s[7:0];
        done = 1'b1;
      end
    end
    if (!done)
    begin
      err_total++;
      final_report();
    end
  endtask

  task automatic chk_rd(input logic [8:0] loc, input logic [7:0] exp);
    logic [7:0] q, qs;
    rd(loc, q, qs);
    chk8(q, exp);
  endtask

  // One-cycle strobe on the load, power-on and brown-out inputs
  task automatic pulse(input logic [2:0] sel);
    @(posedge aclk);
    {program_counter_low, por, bor} <= sel;
    @(posedge aclk);
    {program_counter_low, por, bor} <= 3'h0;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [16:0] tab [24] = '{17'h081ff, 17'h08200, 17'h08318, 17'h08400, 17'h0853f,
      17'h086ff, 17'h087ff, 17'h088ff, 17'h089c7, 17'h08a00, 17'h08b00, 17'h08c00,
      17'h08d00, 17'h08e00, 17'h09140, 17'h092ff, 17'h09300, 17'h0942a, 17'h09802,
      17'h09900, 17'h09cc7, 17'h09d00, 17'h09e00, 17'h09f00};
    foreach (tab[i])
      chk_rd(tab[i][16:8], tab[i][7:0]);
    $display("test reset done");
  endtask

  task automatic t_mask;
    logic [16:0] tab [7] = '{17'h08a1f, 17'h08d59, 17'h09def, 17'h09fcf, 17'h0853f,
      17'h08e03, 17'h098f7};
    foreach (tab[i])
    begin
      wr(tab[i][16:8], 8'hff);
      chk_rd(tab[i][16:8], tab[i][7:0]);
    end
    $display("test mask done");
  endtask

  task automatic t_gaps;
    logic [8:0] tab [10] = '{9'h08f, 9'h090, 9'h095, 9'h096, 9'h097, 9'h09a, 9'h09b,
      9'h080, 9'h185, 9'h105};
    foreach (tab[i])
    begin
      wr(tab[i], 8'hff);
      chk_rd(tab[i], 8'h00);
    end
    wr(9'h099, 8'ha5, 1'b0);
    chk_rd(9'h099, 8'h00);
    chk_rd(9'h093, 8'h00);
    $display("test gaps done");
  endtask

  task automatic t_shared;
    wr(9'h10a, 8'h15);
    chk_rd(9'h08a, 8'h15);
    chk_rd(9'h18a, 8'h15);
    pulse(3'h4);
    chk8({3'h0, pc_high}, 8'h15);
    wr(9'h08a, 8'h0e);
    chk8({3'h0, pc_high}, 8'h15);
    wr(9'h183, 8'ha0);
    chk_rd(9'h083, 8'hb8);
    wr(9'h00b, 8'h81);
    chk_rd(9'h18b, 8'h81);
    $display("test shared done");
  endtask

  task automatic t_variant;
    logic [7:0] q, qs;
    wr(9'h088, 8'h5a);
    rd(9'h088, q, qs);
    chk8(q, 8'h5a);
    chk8(qs, 8'h00);
    rd(9'h089, q, qs);
    chk8(q, 8'hc7);
    chk8(qs, 8'h00);
    wr(9'h10f, 8'hff, 1'b1, 1'b1);
    rd(9'h10f, q, qs);
    chk8(q, 8'h1f);
    chk8(qs, 8'h0f);
    wr(9'h08c, 8'h7f);
    rd(9'h08c, q, qs);
    chk8(q, 8'h7f);
    chk8(qs, 8'h7f);
    $display("test variant done");
  endtask

  task automatic t_events;
    pulse(3'h2);
    chk_rd(9'h08e, 8'h01);
    pulse(3'h1);
    chk_rd(9'h08e, 8'h00);
    prot <= 3'h7;
    tpd <= 2'h0;
    spf <= 2'h0;
    cmp <= 2'h0;
    ssb <= 6'h15;
    ack <= 1'b0;
    tse <= 1'b0;
    chk_rd(9'h083, 8'ha0);
    chk_rd(9'h089, 8'h07);
    chk_rd(9'h09c, 8'h07);
    chk_rd(9'h094, 8'h15);
    chk_rd(9'h091, 8'h00);
    chk_rd(9'h098, 8'hf5);
    $display("test events done");
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_gaps();
    t_shared();
    t_variant();
    t_events();
    final_report();
  end
endmodule // sfr_bank1_test
